// file: src/cac_pkg.sv
// Constants, field positions and types shared by the counter array design.
// Assumes an 8-bit special register port with single-cycle read and write strobes.

package cac_pkg;

   localparam int NUM_MODULES = 5;
   localparam int CNT_WIDTH = 16;

   // Register addresses
   localparam logic [7:0] ADDR_CTRL = 8'hD8;
   localparam logic [7:0] ADDR_MODE = 8'hD9;
   localparam logic [7:0] ADDR_MMODE0 = 8'hDA;
   localparam logic [7:0] ADDR_CNT_LO = 8'hE9;
   localparam logic [7:0] ADDR_CNT_HI = 8'hF9;
   localparam logic [7:0] ADDR_CMPL0 = 8'hEA;
   localparam logic [7:0] ADDR_CMPH0 = 8'hFA;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;

   // Control register fields
   localparam int CTRL_CF = 7;
   localparam int CTRL_CR = 6;
   localparam int CTRL_UNUSED = 5;

   // Array mode register fields
   localparam int MODE_IDLE_SUSPEND_CONTROL = 7;
   localparam int MODE_CPS_HI = 2;
   localparam int MODE_CPS_LO = 1;
   localparam int MODE_ECF = 0;

   // Module mode register fields
   localparam int MM_ECOM = 6;
   localparam int MM_CAPP = 5;
   localparam int MM_CAPN = 4;
   localparam int MM_MAT = 3;
   localparam int MM_TOG = 2;
   localparam int MM_PWM = 1;
   localparam int MM_ECCF = 0;

   // Prescaler terminal counts for the two clock dividers
   localparam logic [3:0] DIV_SLOW_LAST = 4'hB;
   localparam logic [3:0] DIV_FAST_LAST = 4'h3;

   typedef enum logic [1:0] {
      TB_DIV12 = 2'b00,
      TB_DIV4 = 2'b01,
      TB_T0OVF = 2'b10,
      TB_EXT = 2'b11
   } cac_tb_t;

   // True when addr falls in the five-entry group starting at base
   function automatic logic in_group(input logic [7:0] addr, input logic [7:0] base);
      logic [7:0] d;
      d = addr - base;
      return d < 8'h05;
   endfunction

   function automatic logic [2:0] group_index(input logic [7:0] addr, input logic [7:0] base);
      logic [7:0] d;
      d = addr - base;
      return d[2:0];
   endfunction

endpackage

// file: src/cac_module.sv
// One capture/compare module: its mode byte, its 16-bit register and its pin.
// Assumes the counter and its step pulse come from the array top, same clock.
`timescale 1ns/1ns

module cac_module
   import cac_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Counter view
   input wire logic [15:0] count,
   input wire logic step,
   input wire logic active,
   // Register writes
   input wire logic wr_mode,
   input wire logic wr_lo,
   input wire logic wr_hi,
   input wire logic [7:0] wdata,
   // Pin
   input wire logic pin_in,
   output logic pin,
   // State and events
   output logic [6:0] mode,
   output logic [15:0] cmp,
   output logic event_pulse
);
   logic sync1, sync2, prev;
   logic [6:0] next_mode;
   logic [15:0] next_cmp;
   logic next_pin;
   logic rise, fall, capture, match16, duty, low_match, low_wrap;

   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   always_comb begin
      rise = sync2 & ~prev;
      fall = ~sync2 & prev;
      capture = active & ((mode[MM_CAPP] & rise) | (mode[MM_CAPN] & fall));
      match16 = step & mode[MM_ECOM] & (count == cmp);
      duty = mode[MM_ECOM] & mode[MM_PWM];
      low_match = step & (count[7:0] == cmp[7:0]);
      low_wrap = step & (count[7:0] == 8'h00);
      next_mode = wr_mode ? wdata[6:0] : mode;
      next_cmp = cmp;
      if (wr_lo) begin
         next_cmp[7:0] = wdata;
      end
      if (wr_hi) begin
         next_cmp[15:8] = wdata;
      end
      if (duty && low_wrap) begin
         next_cmp[7:0] = cmp[15:8];
      end
      if (capture) begin
         next_cmp = count;
      end
      next_pin = pin;
      if (duty) begin
         if (low_wrap) begin
            next_pin = 1'b0;
         end
         if (low_match) begin
            next_pin = 1'b1;
         end
      end else if (match16 && mode[MM_MAT] && mode[MM_TOG]) begin
         next_pin = ~pin;
      end
      event_pulse = capture | (match16 & mode[MM_MAT] & ~duty);
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mode <= 7'h00;
         cmp <= RST_WORD;
         pin <= 1'b0;
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         prev <= 1'b0;
      end else begin
         mode <= next_mode;
         cmp <= next_cmp;
         pin <= next_pin;
         sync1 <= pin_in;
         sync2 <= sync1;
         prev <= sync2;
      end
   end

   chk_capture_load: assert property (capture |=> cmp == $past(count))
      else $error("capture did not load counter");
   chk_toggle_pin: assert property ((match16 && mode[MM_MAT] && mode[MM_TOG] && !duty) |=> pin != $past(pin))
      else $error("toggle match did not invert pin");
   chk_duty_reload: assert property ((duty && low_wrap && !capture && !wr_lo) |=> cmp[7:0] == $past(cmp[15:8]))
      else $error("duty low byte not reloaded");
   chk_duty_set: assert property ((duty && low_match) |=> pin)
      else $error("duty pin not set on low match");

endmodule

// file: src/cac_top.sv
// Counter array top: 16-bit counter, timebase, flags, register port, five modules.
// Assumes one-cycle read and write strobes on the register port; read data follows one clock later.
`timescale 1ns/1ns

module cac_top
   import cac_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RSTN,
   // Register port
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   output logic [7:0] SFR_RDATA,
   // Interrupt
   input wire logic GLOBAL_IRQ_ENABLE,
   input wire logic ARRAY_IRQ_ENABLE,
   output logic IRQ,
   // Core state and count sources
   input wire logic CORE_IDLE,
   input wire logic TIMER0_OVERFLOW,
   input wire logic EXTERNAL_COUNT_INPUT,
   // Module pins
   input wire logic [cac_pkg::NUM_MODULES-1:0] MODULE_PIN_IN,
   output logic [cac_pkg::NUM_MODULES-1:0] MODULE_PIN
);

   // Control register state
   logic counter_run, next_counter_run;
   logic counter_overflow_flag, next_counter_overflow_flag;
   logic [NUM_MODULES-1:0] module_event_flag, next_module_event_flag;

   // Array mode register state
   logic idle_suspend_control, next_idle_suspend_control;
   cac_tb_t timebase, next_timebase;
   logic overflow_irq_enable, next_overflow_irq_enable;

   // Counter and timebase
   logic [15:0] count, next_count;
   logic [7:0] snapshot, next_snapshot;
   logic [3:0] prescale, next_prescale;
   logic eci_sync1, eci_sync2, eci_prev;
   logic step, next_step;
   logic active, modules_on, tick, tick_src, eci_fall, pre_last, wrap;

   // Read data and interrupt
   logic [7:0] next_rdata;
   logic next_irq;

   // Decode
   logic wr_ctrl, wr_mode, wr_cnt_lo, wr_cnt_hi, rd_cnt_lo;
   logic [2:0] mm_idx, cl_idx, ch_idx;
   logic [NUM_MODULES-1:0] wr_mm, wr_cl, wr_ch, mod_event, eccf;

   // Module views
   logic [6:0] mod_mode [NUM_MODULES];
   logic [15:0] mod_cmp [NUM_MODULES];

   always_comb begin
      wr_ctrl = SFR_WR & (SFR_ADDR == ADDR_CTRL);
      wr_mode = SFR_WR & (SFR_ADDR == ADDR_MODE);
      wr_cnt_lo = SFR_WR & (SFR_ADDR == ADDR_CNT_LO);
      wr_cnt_hi = SFR_WR & (SFR_ADDR == ADDR_CNT_HI);
      rd_cnt_lo = SFR_RD & (SFR_ADDR == ADDR_CNT_LO);
      mm_idx = group_index(SFR_ADDR, ADDR_MMODE0);
      cl_idx = group_index(SFR_ADDR, ADDR_CMPL0);
      ch_idx = group_index(SFR_ADDR, ADDR_CMPH0);
      for (int i = 0; i < NUM_MODULES; i++) begin
         wr_mm[i] = SFR_WR & in_group(SFR_ADDR, ADDR_MMODE0) & (mm_idx == i[2:0]);
         wr_cl[i] = SFR_WR & in_group(SFR_ADDR, ADDR_CMPL0) & (cl_idx == i[2:0]);
         wr_ch[i] = SFR_WR & in_group(SFR_ADDR, ADDR_CMPH0) & (ch_idx == i[2:0]);
         eccf[i] = mod_mode[i][MM_ECCF];
      end
   end

   // Timebase and counter
   always_comb begin
      active = counter_run & ~(idle_suspend_control & CORE_IDLE);
      // Captures follow the pins while the counter is stopped; only idle suspend halts them
      modules_on = ~(idle_suspend_control & CORE_IDLE);
      eci_fall = eci_prev & ~eci_sync2;
      pre_last = (timebase == TB_DIV12) ? (prescale == DIV_SLOW_LAST) : (prescale[1:0] == DIV_FAST_LAST[1:0]);
      next_prescale = prescale;
      if (active) begin
         next_prescale = pre_last ? 4'h0 : prescale + 4'h1;
      end
      case (timebase)
         TB_DIV12: tick_src = pre_last;
         TB_DIV4: tick_src = pre_last;
         TB_T0OVF: tick_src = TIMER0_OVERFLOW;
         TB_EXT: tick_src = eci_fall;
         default: tick_src = 1'b0;
      endcase
      tick = active & tick_src;
      wrap = tick & (count == 16'hFFFF);
      next_count = count;
      if (wr_cnt_lo || wr_cnt_hi) begin
         if (wr_cnt_lo) begin
            next_count[7:0] = SFR_WDATA;
         end
         if (wr_cnt_hi) begin
            next_count[15:8] = SFR_WDATA;
         end
      end else if (tick) begin
         next_count = count + 16'h0001;
      end
      next_step = tick & ~(wr_cnt_lo | wr_cnt_hi);
      // Reading the low byte freezes the high byte for the next read
      next_snapshot = rd_cnt_lo ? count[15:8] : snapshot;
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         count <= RST_WORD;
         snapshot <= RST_BYTE;
         prescale <= 4'h0;
         step <= 1'b0;
         eci_sync1 <= 1'b0;
         eci_sync2 <= 1'b0;
         eci_prev <= 1'b0;
      end else begin
         count <= next_count;
         snapshot <= next_snapshot;
         prescale <= next_prescale;
         step <= next_step;
         eci_sync1 <= EXTERNAL_COUNT_INPUT;
         eci_sync2 <= eci_sync1;
         eci_prev <= eci_sync2;
      end
   end

   // Control, mode and flags; hardware sets win over software writes
   always_comb begin
      next_counter_run = wr_ctrl ? SFR_WDATA[CTRL_CR] : counter_run;
      next_counter_overflow_flag = wrap | (wr_ctrl ? SFR_WDATA[CTRL_CF] : counter_overflow_flag);
      next_module_event_flag = mod_event | (wr_ctrl ? SFR_WDATA[NUM_MODULES-1:0] : module_event_flag);
      next_idle_suspend_control = wr_mode ? SFR_WDATA[MODE_IDLE_SUSPEND_CONTROL] : idle_suspend_control;
      next_timebase = wr_mode ? cac_tb_t'(SFR_WDATA[MODE_CPS_HI:MODE_CPS_LO]) : timebase;
      next_overflow_irq_enable = wr_mode ? SFR_WDATA[MODE_ECF] : overflow_irq_enable;
      next_irq = GLOBAL_IRQ_ENABLE & ARRAY_IRQ_ENABLE
         & ((counter_overflow_flag & overflow_irq_enable) | (|(module_event_flag & eccf)));
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         counter_run <= 1'b0;
         counter_overflow_flag <= 1'b0;
         module_event_flag <= '0;
         idle_suspend_control <= 1'b0;
         timebase <= TB_DIV12;
         overflow_irq_enable <= 1'b0;
         IRQ <= 1'b0;
      end else begin
         counter_run <= next_counter_run;
         counter_overflow_flag <= next_counter_overflow_flag;
         module_event_flag <= next_module_event_flag;
         idle_suspend_control <= next_idle_suspend_control;
         timebase <= next_timebase;
         overflow_irq_enable <= next_overflow_irq_enable;
         IRQ <= next_irq;
      end
   end

   // Read data; reads change nothing but the snapshot
   always_comb begin
      next_rdata = SFR_RDATA;
      if (SFR_RD) begin
         next_rdata = RST_BYTE;
         if (SFR_ADDR == ADDR_CTRL) begin
            next_rdata[CTRL_CF] = counter_overflow_flag;
            next_rdata[CTRL_CR] = counter_run;
            next_rdata[CTRL_UNUSED] = 1'b0;
            next_rdata[NUM_MODULES-1:0] = module_event_flag;
         end else if (SFR_ADDR == ADDR_MODE) begin
            next_rdata[MODE_IDLE_SUSPEND_CONTROL] = idle_suspend_control;
            next_rdata[MODE_CPS_HI:MODE_CPS_LO] = timebase;
            next_rdata[MODE_ECF] = overflow_irq_enable;
         end else if (SFR_ADDR == ADDR_CNT_LO) begin
            next_rdata = count[7:0];
         end else if (SFR_ADDR == ADDR_CNT_HI) begin
            next_rdata = snapshot;
         end else if (in_group(SFR_ADDR, ADDR_MMODE0)) begin
            next_rdata = {1'b0, mod_mode[mm_idx]};
         end else if (in_group(SFR_ADDR, ADDR_CMPL0)) begin
            next_rdata = mod_cmp[cl_idx][7:0];
         end else if (in_group(SFR_ADDR, ADDR_CMPH0)) begin
            next_rdata = mod_cmp[ch_idx][15:8];
         end
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         SFR_RDATA <= RST_BYTE;
      end else begin
         SFR_RDATA <= next_rdata;
      end
   end

   // Five independent modules
   for (genvar g = 0; g < NUM_MODULES; g++) begin : g_mod
      cac_module u_mod (
         .clock(CLOCK),
         .rstn(RSTN),
         .count(count),
         .step(step),
         .active(modules_on),
         .wr_mode(wr_mm[g]),
         .wr_lo(wr_cl[g]),
         .wr_hi(wr_ch[g]),
         .wdata(SFR_WDATA),
         .pin_in(MODULE_PIN_IN[g]),
         .pin(MODULE_PIN[g]),
         .mode(mod_mode[g]),
         .cmp(mod_cmp[g]),
         .event_pulse(mod_event[g])
      );
   end

   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RSTN);

   chk_count_step: assert property ((tick && !wr_cnt_lo && !wr_cnt_hi) |=> count == $past(count) + 16'h0001)
      else $error("counter did not advance by one");
   chk_overflow_set: assert property (wrap |=> counter_overflow_flag ##1 counter_overflow_flag || $past(wr_ctrl))
      else $error("overflow flag not set on wrap");
   chk_overflow_hold: assert property ((counter_overflow_flag && !wr_ctrl) |=> counter_overflow_flag)
      else $error("overflow flag dropped without a write");
   chk_stop_hold: assert property ((!counter_run && !wr_cnt_lo && !wr_cnt_hi) |=> $stable(count))
      else $error("counter moved while stopped");
   chk_idle_hold: assert property ((idle_suspend_control && CORE_IDLE && !wr_cnt_lo && !wr_cnt_hi) |=> $stable(count))
      else $error("counter moved while suspended");
   chk_snapshot_read: assert property ((rd_cnt_lo ##1 (SFR_RD && SFR_ADDR == ADDR_CNT_HI)) |=> SFR_RDATA == $past(count[15:8], 2))
      else $error("high byte read did not return snapshot");
   chk_irq_gate: assert property ((!GLOBAL_IRQ_ENABLE || !ARRAY_IRQ_ENABLE) |=> !IRQ)
      else $error("interrupt raised while disabled");
   chk_unused_zero: assert property ((SFR_RD && SFR_ADDR == ADDR_CTRL) |=> !SFR_RDATA[CTRL_UNUSED])
      else $error("unused control bit read as one");
   chk_flag_hold: assert property ((module_event_flag[0] && !wr_ctrl) |=> module_event_flag[0])
      else $error("module flag dropped without a write");
   chk_flag_set: assert property (mod_event[1] |=> module_event_flag[1])
      else $error("module event did not set flag");
   chk_read_still: assert property ((active && tick && SFR_RD && SFR_ADDR == ADDR_CNT_LO) |=> count != $past(count))
      else $error("counter read stalled counting");

endmodule

// file: bench/cac_pins.sv
// Pin-side model: capture pin levels with a settable lag and a free-running external count line.
// Assumes the bench sets the wanted capture levels; shares the array clock.
`timescale 1ns/1ns

module cac_pins #(
   parameter int CAP_DELAY = 2,
   parameter int EXT_HALF = 4
) (
   // Clock
   input wire logic clock,
   // Commands from the bench
   input wire logic [4:0] cap_level,
   // Pins toward the array
   output logic [4:0] pin_in = 5'h00,
   output logic ext_count = 1'b1
);
   logic [4:0] dly [0:CAP_DELAY-1] = '{default: 5'h00};
   int half_cnt = 0;

   always @(posedge clock) begin
      dly[0] <= cap_level;
      for (int i = 1; i < CAP_DELAY; i++) begin
         dly[i] <= dly[i-1];
      end
      // Lagged edges exercise the array's own synchroniser
      pin_in <= dly[CAP_DELAY-1];
      if (half_cnt == EXT_HALF - 1) begin
         half_cnt <= 0;
         // One fall every eight clocks, inside the allowed maximum rate
         ext_count <= ~ext_count;
      end else begin
         half_cnt <= half_cnt + 1;
      end
   end
endmodule

// file: bench/testbench.sv
// Self-checking bench for the counter array top.
// Assumes the pin model drives capture pins and the external count line.
`timescale 1ns/1ns

module testbench;
   import cac_pkg::*;
   typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata;} cac_rw_t;
   typedef struct packed {logic [7:0] mode; logic [7:0] ctrl; logic [7:0] idle; logic [7:0] step;} cac_cnt_t;
   logic CLOCK = 1'b0;
   logic RSTN = 1'b0;
   logic [7:0] SFR_ADDR = 8'h00;
   logic SFR_WR = 1'b0;
   logic SFR_RD = 1'b0;
   logic [7:0] SFR_WDATA = 8'h00;
   logic [7:0] SFR_RDATA;
   logic GLOBAL_IRQ_ENABLE = 1'b0;
   logic ARRAY_IRQ_ENABLE = 1'b0;
   logic IRQ;
   logic CORE_IDLE = 1'b0;
   logic TIMER0_OVERFLOW = 1'b0;
   logic EXTERNAL_COUNT_INPUT;
   logic [NUM_MODULES-1:0] MODULE_PIN_IN;
   logic [NUM_MODULES-1:0] MODULE_PIN;
   logic [4:0] cap_level = 5'h00;
   logic [7:0] a;
   logic [7:0] b;
   int err_total = 0;
   int checks = 0;
   int t0_phase = 0;
   int hi_cnt;
   cac_rw_t rw_rows [0:10] = '{24'hD8_20_00, 24'hD8_1F_1F, 24'hD8_00_00, 24'hD9_87_87, 24'hD9_00_00,
      24'hDA_FF_7F, 24'hDA_00_00, 24'hEA_34_34, 24'hFA_12_12, 24'h80_55_00, 24'hDE_41_41};
   cac_cnt_t cnt_rows [0:7] = '{32'h00_40_00_04, 32'h02_40_00_0C, 32'h04_40_00_08, 32'h06_40_00_06,
      32'h02_00_00_00, 32'h82_40_01_00, 32'h02_40_01_0C, 32'h82_40_00_0C};

   cac_top cac_top_i (.CLOCK(CLOCK), .RSTN(RSTN), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
      .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
      .ARRAY_IRQ_ENABLE(ARRAY_IRQ_ENABLE), .IRQ(IRQ), .CORE_IDLE(CORE_IDLE), .TIMER0_OVERFLOW(TIMER0_OVERFLOW),
      .EXTERNAL_COUNT_INPUT(EXTERNAL_COUNT_INPUT), .MODULE_PIN_IN(MODULE_PIN_IN), .MODULE_PIN(MODULE_PIN));

   cac_pins #(.CAP_DELAY(3), .EXT_HALF(4)) cac_pins_i (.clock(CLOCK), .cap_level(cap_level),
      .pin_in(MODULE_PIN_IN), .ext_count(EXTERNAL_COUNT_INPUT));

   always #20 CLOCK = ~CLOCK;

   // Timer-0 stand-in: one pulse every six clocks
   always @(negedge CLOCK) begin
      t0_phase <= (t0_phase + 1) % 6;
      TIMER0_OVERFLOW <= (t0_phase == 5);
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      SFR_ADDR = addr;
      SFR_WDATA = data;
      SFR_WR = 1'b1;
      @(negedge CLOCK);
      SFR_WR = 1'b0;
      @(negedge CLOCK);
   endtask

   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      SFR_ADDR = addr;
      SFR_RD = 1'b1;
      @(negedge CLOCK);
      SFR_RD = 1'b0;
      data = SFR_RDATA;
      @(negedge CLOCK);
   endtask

   task automatic rdc(input logic [7:0] addr, input logic [7:0] exp, input string what);
      logic [7:0] d;
      rd(addr, d);
      check(d, exp, what);
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(negedge CLOCK);
      err_total++;
      $display("unexpected at %0t: watchdog expired", $time);
      test_done();
   end

   initial begin
      repeat (4) @(negedge CLOCK);
      RSTN = 1'b1;
      @(negedge CLOCK);
      foreach (rw_rows[i]) begin
         wr(rw_rows[i].addr, rw_rows[i].wdata);
         rdc(rw_rows[i].addr, rw_rows[i].rdata, "register row");
      end
      // Counter steps over exactly 48 clocks per timebase, run and idle setting
      foreach (cnt_rows[i]) begin
         wr(ADDR_MODE, cnt_rows[i].mode);
         wr(ADDR_CTRL, cnt_rows[i].ctrl);
         CORE_IDLE = cnt_rows[i].idle[0];
         repeat (8) @(negedge CLOCK);
         rd(ADDR_CNT_LO, a);
         repeat (46) @(negedge CLOCK);
         rd(ADDR_CNT_LO, b);
         check(b - a, cnt_rows[i].step, "count step");
      end
      CORE_IDLE = 1'b0;
      // Overflow flag, its masking and its persistence
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CNT_LO, 8'hFC);
      wr(ADDR_CNT_HI, 8'hFF);
      wr(ADDR_MODE, 8'h03);
      wr(ADDR_CTRL, 8'h40);
      repeat (40) @(negedge CLOCK);
      rdc(ADDR_CTRL, 8'hC0, "overflow flag");
      check({7'h00, IRQ}, 8'h00, "irq masked");
      GLOBAL_IRQ_ENABLE = 1'b1;
      ARRAY_IRQ_ENABLE = 1'b1;
      repeat (3) @(negedge CLOCK);
      check({7'h00, IRQ}, 8'h01, "overflow irq");
      ARRAY_IRQ_ENABLE = 1'b0;
      repeat (200) @(negedge CLOCK);
      check({7'h00, IRQ}, 8'h00, "irq block mask");
      rdc(ADDR_CTRL, 8'hC0, "overflow held");
      wr(ADDR_CTRL, 8'h00);
      rdc(ADDR_CTRL, 8'h00, "overflow cleared");
      // Module 1 toggles and flags, module 2 flags only
      wr(ADDR_CNT_LO, 8'h00);
      wr(ADDR_CNT_HI, 8'h00);
      wr(ADDR_CMPL0 + 8'h01, 8'h10);
      wr(ADDR_CMPL0 + 8'h02, 8'h10);
      wr(ADDR_MMODE0 + 8'h01, 8'h4D);
      wr(ADDR_MMODE0 + 8'h02, 8'h48);
      wr(ADDR_MODE, 8'h02);
      ARRAY_IRQ_ENABLE = 1'b1;
      wr(ADDR_CTRL, 8'h40);
      repeat (90) @(negedge CLOCK);
      rdc(ADDR_CTRL, 8'h46, "match flags");
      check({3'h0, MODULE_PIN}, 8'h02, "toggle pins");
      check({7'h00, IRQ}, 8'h01, "module irq");
      wr(ADDR_CTRL, 8'h00);
      // Capture on rising, falling and both edges with the counter held
      wr(ADDR_MMODE0 + 8'h01, 8'h00);
      wr(ADDR_MMODE0 + 8'h02, 8'h00);
      wr(ADDR_MMODE0, 8'h20);
      wr(ADDR_MMODE0 + 8'h03, 8'h10);
      wr(ADDR_MMODE0 + 8'h04, 8'h30);
      wr(ADDR_CNT_LO, 8'h5A);
      wr(ADDR_CNT_HI, 8'hA5);
      cap_level = 5'h1F;
      repeat (10) @(negedge CLOCK);
      rdc(ADDR_CTRL, 8'h11, "rise flags");
      rdc(ADDR_CMPL0, 8'h5A, "capture low");
      rdc(ADDR_CMPH0, 8'hA5, "capture high");
      wr(ADDR_CNT_LO, 8'h02);
      wr(ADDR_CNT_HI, 8'h01);
      cap_level = 5'h00;
      repeat (10) @(negedge CLOCK);
      rdc(ADDR_CTRL, 8'h19, "fall flags");
      rdc(ADDR_CMPL0 + 8'h03, 8'h02, "fall capture");
      rdc(ADDR_CMPH0 + 8'h04, 8'h01, "both capture");
      rdc(ADDR_CMPL0, 8'h5A, "rise untouched");
      wr(ADDR_CTRL, 8'h00);
      // Duty output: reload from the high byte, then a quarter duty
      wr(ADDR_MMODE0 + 8'h02, 8'h42);
      wr(ADDR_CMPL0 + 8'h02, 8'h80);
      wr(ADDR_CMPH0 + 8'h02, 8'hC0);
      wr(ADDR_CNT_LO, 8'h00);
      wr(ADDR_CNT_HI, 8'h00);
      wr(ADDR_CTRL, 8'h40);
      repeat (1100) @(negedge CLOCK);
      hi_cnt = 0;
      repeat (256) begin
         repeat (4) @(negedge CLOCK);
         if (MODULE_PIN[2] === 1'b1) hi_cnt++;
      end
      check(hi_cnt[7:0], 8'h40, "duty high count");
      rdc(ADDR_CMPL0 + 8'h02, 8'hC0, "duty reload");
      // Reads spaced three clocks apart land on every prescaler phase
      rd(ADDR_CNT_LO, a);
      repeat (4) begin
         @(negedge CLOCK);
         rd(ADDR_CNT_LO, b);
      end
      check(b - a, 8'h03, "reads keep counting");
      // Counter high reads return the snapshot, not the live byte
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CNT_LO, 8'hFF);
      wr(ADDR_CNT_HI, 8'h12);
      rdc(ADDR_CNT_LO, 8'hFF, "count low");
      wr(ADDR_CNT_HI, 8'h77);
      rdc(ADDR_CNT_HI, 8'h12, "snapshot");
      rdc(ADDR_CNT_LO, 8'hFF, "count low again");
      rdc(ADDR_CNT_HI, 8'h77, "new snapshot");
      // Back-to-back low then high read, as software pairs them
      SFR_ADDR = ADDR_CNT_LO;
      SFR_RD = 1'b1;
      @(negedge CLOCK);
      a = SFR_RDATA;
      SFR_ADDR = ADDR_CNT_HI;
      @(negedge CLOCK);
      SFR_RD = 1'b0;
      b = SFR_RDATA;
      @(negedge CLOCK);
      check(a, 8'hFF, "paired low");
      check(b, 8'h77, "paired high");
      // Reset in mid-run
      wr(ADDR_CTRL, 8'h40);
      RSTN = 1'b0;
      repeat (4) @(negedge CLOCK);
      check({3'h0, MODULE_PIN}, 8'h00, "pins in reset");
      RSTN = 1'b1;
      @(negedge CLOCK);
      rdc(ADDR_CTRL, RST_BYTE, "ctrl reset");
      rdc(ADDR_MODE, RST_BYTE, "mode reset");
      rdc(ADDR_MMODE0 + 8'h02, RST_BYTE, "module mode reset");
      rdc(ADDR_CMPL0 + 8'h02, RST_BYTE, "compare reset");
      rdc(ADDR_CNT_LO, RST_BYTE, "count reset");
      test_done();
   end
endmodule
